/* File: core/qeo_encoder.sv */
// quadrature encoder output stage with power-up diagnostic state and apb register access
//
// What this block does
// - with the release input low, quadrature and index start once offset compensation ends, within 50 ms.
// - release high at power-up holds both quadrature channels and the index high together.
// - in normal operation the index is never high unless both channels are low.
// - pulling release low leaves the all-high state and outputs stay enabled if it rises again.
// - the up indicator turns on while the field magnitude rises.
// - the down indicator turns on while the field magnitude falls.
// - both indicators turn on together when the field is too strong or too weak.
// - both indicators stay off while the field is in range and steady.
// - each indicator is open drain, releasing when off and pulling low when on.
// - the two indicators wired together read high only for a steady in-range field.
// - the 8-bit angle gives 64 quadrature cycles and 256 channel edges per turn.
// - exactly one index pulse appears per revolution.
// - with the reverse bit clear, channel a leads b for clockwise motion and b leads a for counter-clockwise motion.
// - the index pulse lasts one angle step.
// - after a reversal nothing changes until the angle moves back past a half-step band.
`timescale 1ns/1ps
`default_nettype none
`include "qeo_defs.svh"

module qeo_encoder
    import qeo_pkg::*;
#(
    parameter int unsigned COMP_CYCLES = `QEO_COMP_CYCLES
)
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`QEO_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic      [31:0]            prdata,
    output logic                        pslverr,
    input  wire logic [8:0]             fine_angle,
    input  wire logic                   field_rising_flag,
    input  wire logic                   field_falling_flag,
    input  wire logic                   field_too_strong,
    input  wire logic                   field_too_weak,
    input  wire logic                   output_release_n,
    output logic                        quad_a,
    output logic                        quad_b,
    output logic                        index_out,
    output logic                        field_up_indicator,
    output logic                        field_up_indicator_oe,
    output logic                        field_down_indicator,
    output logic                        field_down_indicator_oe,
    output logic                        irq
);

    // ********************************************************************
    // declarations
    // ********************************************************************
    localparam logic [`QEO_COMP_CNT_W-1:0] COMP_LAST = COMP_CYCLES[`QEO_COMP_CNT_W-1:0];

    // whole top-level state
    qeo_top_s              st;
    qeo_top_s              next_st;

    logic [7:0]            pos;
    logic [8:0]            fine_eff;
    logic                  snap;
    logic                  comp_done;
    logic                  invalid;
    logic                  moving;
    logic                  access;
    logic                  commit;
    logic                  mapped;

    logic [`QEO_IRQ_W-1:0] irq_event;
    logic [`QEO_IRQ_W-1:0] irq_clear;
    logic [31:0]           status_word;

    // ********************************************************************
    // angle tracking and field indicators
    // ********************************************************************
    // direction reverse negates the angle, so the leading channel swaps with it
    assign fine_eff = st.rev ? 9'(~fine_angle + 9'h001) : fine_angle;

    // while not running the tracker follows the angle directly, so no burst of
    // catch-up steps appears when the outputs come alive
    assign snap = (st.pwr != QEO_RUN);

    // one step per edge at most while running; snaps straight to the angle otherwise
    qeo_hyst u_hyst (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .snap       (snap),
        .fine_angle (fine_eff),
        .pos        (pos)
    );

    // data pins tied low
    qeo_field_diag u_diag (
        .pclk               (pclk),
        .presetn            (presetn),
        .ce                 (ce),
        .field_rising_flag  (field_rising_flag),
        .field_falling_flag (field_falling_flag),
        .field_too_strong   (field_too_strong),
        .field_too_weak     (field_too_weak),
        .up_o               (field_up_indicator),
        .up_oe              (field_up_indicator_oe),
        .down_o             (field_down_indicator),
        .down_oe            (field_down_indicator_oe)
    );

    // ********************************************************************
    // helper terms
    // ********************************************************************
    // counter holds at its end
    assign comp_done = (st.comp_cnt == COMP_LAST);
    assign invalid   = field_too_strong | field_too_weak;
    assign moving    = (field_rising_flag ^ field_falling_flag) & ~invalid;
    // commit: completing edge only
    assign access    = psel & penable;
    assign commit    = access & st.pready;
    assign mapped    = (paddr == `QEO_CTRL_OFS) || (paddr == `QEO_STATUS_OFS) ||
                       (paddr == `QEO_IRQ_STAT_OFS) || (paddr == `QEO_IRQ_MASK_OFS);

    // status word shows the live sequencing and output state
    always_comb begin
        status_word                       = 32'h0000_0000;
        status_word[`QEO_ST_COMP_BIT]     = comp_done;
        status_word[`QEO_ST_DIAG_BIT]     = st.diag_mode;
        status_word[`QEO_ST_REL_BIT]      = st.release_seen;
        status_word[`QEO_ST_RUN_BIT]      = (st.pwr == QEO_RUN);
        status_word[`QEO_ST_A_BIT]        = st.quad_a;
        status_word[`QEO_ST_B_BIT]        = st.quad_b;
        status_word[`QEO_ST_IDX_BIT]      = st.index_out;
        status_word[`QEO_ST_POS_LSB +: 8] = pos;
    end

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        next_st   = st;
        irq_event = '0;
        irq_clear = '0;

        // power-up sequencing: the strap is caught on the first enabled edge
        // after reset release, never by the asynchronous reset itself
        case (st.pwr)
            QEO_STRAP: begin
                next_st.diag_mode = output_release_n;
                next_st.pwr       = QEO_WAIT;
            end
            QEO_WAIT: begin
                // never wraps
                if (!comp_done) begin
                    next_st.comp_cnt = st.comp_cnt + 1'b1;
                end
                // tied-low strap: released
                if (!output_release_n || !st.diag_mode) begin
                    next_st.release_seen = 1'b1;
                end
                // both needed to go live
                if (comp_done && st.release_seen) begin
                    next_st.pwr = QEO_RUN;
                    irq_event[`QEO_IRQ_ENABLE_BIT] = 1'b1;
                end
            end
            QEO_RUN: begin
                // select ignored from here
                next_st.pwr = QEO_RUN;
            end
            default: begin
                // illegal code: restart
                next_st.pwr = QEO_STRAP;
            end
        endcase

        // incremental outputs: a = p1^p0, b = p1 walks 00,10,11,01 as the angle rises
        if (st.pwr == QEO_RUN) begin
            next_st.quad_a    = pos[1] ^ pos[0];
            next_st.quad_b    = pos[1];
            next_st.index_out = (pos == 8'h00);
        end else if (st.pwr == QEO_WAIT && st.diag_mode && !st.release_seen) begin
            // all high until released
            next_st.quad_a    = 1'b1;
            next_st.quad_b    = 1'b1;
            next_st.index_out = 1'b1;
        end else begin
            // low while compensating
            next_st.quad_a    = 1'b0;
            next_st.quad_b    = 1'b0;
            next_st.index_out = 1'b0;
        end

        // events for the interrupt status
        // detectors start at idle level
        next_st.prev_invalid = invalid;
        next_st.prev_move    = moving;
        irq_event[`QEO_IRQ_INDEX_BIT]   = next_st.index_out & ~st.index_out &
                                          (st.pwr == QEO_RUN);
        irq_event[`QEO_IRQ_INVALID_BIT] = invalid & ~st.prev_invalid;
        irq_event[`QEO_IRQ_MOVE_BIT]    = moving & ~st.prev_move;

        // apb: one wait state, pready rises in the second access cycle and the
        // write lands on the edge that samples it high
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h0000_0000;
        if (access && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = ~mapped;
            if (!pwrite) begin
                case (paddr)
                    `QEO_CTRL_OFS:     next_st.prdata = {31'h0000_0000, st.rev};
                    `QEO_STATUS_OFS:   next_st.prdata = status_word;
                    `QEO_IRQ_STAT_OFS: next_st.prdata = {28'h000_0000, st.irq_stat};
                    `QEO_IRQ_MASK_OFS: next_st.prdata = {28'h000_0000, st.irq_mask};
                    default:           next_st.prdata = 32'h0000_0000;
                endcase
            end
        end

        // writes land on completing edge
        if (commit && pwrite) begin
            case (paddr)
                `QEO_CTRL_OFS:     next_st.rev      = pwdata[`QEO_CTRL_REV_BIT];
                `QEO_IRQ_STAT_OFS: irq_clear        = pwdata[`QEO_IRQ_W-1:0];
                `QEO_IRQ_MASK_OFS: next_st.irq_mask = pwdata[`QEO_IRQ_W-1:0];
                default:           irq_clear        = '0;
            endcase
        end

        // write-one-to-clear, a new event in the same cycle wins over the clear
        next_st.irq_stat = (st.irq_stat & ~irq_clear) | irq_event;
        next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
    end

    // ********************************************************************
    // state register
    // ********************************************************************
    // ce low freezes everything, the bus included; a master must not start
    // a transfer it expects answered while ce is held low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.pwr      <= QEO_STRAP;
            st.rev      <= `QEO_CTRL_RST;
            st.irq_mask <= `QEO_IRQ_MASK_RST;
            st.irq_stat <= `QEO_IRQ_STAT_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign quad_a    = st.quad_a;
    assign quad_b    = st.quad_b;
    assign index_out = st.index_out;
    assign pready    = st.pready;
    assign prdata    = st.prdata;
    assign pslverr   = st.pslverr;
    assign irq       = st.irq;

    // ********************************************************************
    // checks
    // ********************************************************************
    comp_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.pwr == QEO_RUN) |-> (st.comp_cnt == COMP_LAST))
        else $error("outputs enabled before offset compensation ended");

    diag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st.pwr == QEO_WAIT && st.diag_mode && !st.release_seen)
        |=> (quad_a && quad_b && index_out))
        else $error("diagnostic state does not hold all outputs high");

    idx_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (index_out && $past(st.pwr == QEO_RUN)) |-> (!quad_a && !quad_b))
        else $error("index high with a quadrature channel high");

    release_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.pwr == QEO_RUN) |=> (st.pwr == QEO_RUN))
        else $error("outputs left the enabled state");

    release_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st.pwr == QEO_WAIT && comp_done && st.release_seen) |=> (st.pwr == QEO_RUN))
        else $error("release seen but outputs not enabled");

    gray_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.pwr == QEO_RUN && $past(st.pwr == QEO_RUN, 2))
        |-> ($countones({quad_a, quad_b} ^ {$past(quad_a), $past(quad_b)}) <= 1))
        else $error("both quadrature channels toggled at once");

    // rising angle: 00, 10, 11, 01
    a_leads_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st.pwr == QEO_RUN && $past(st.pwr == QEO_RUN) && pos == $past(pos) + 8'h01)
        |=> ({quad_a, quad_b} == {~$past(quad_b), $past(quad_a)}))
        else $error("quadrature phase wrong for rising angle");

    // falling angle: same walk backwards
    b_leads_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st.pwr == QEO_RUN && $past(st.pwr == QEO_RUN) && pos == $past(pos) - 8'h01)
        |=> ({quad_a, quad_b} == {$past(quad_b), ~$past(quad_a)}))
        else $error("quadrature phase wrong for falling angle");

    idx_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st.pwr == QEO_RUN) |=> (index_out == ($past(pos) == 8'h00)))
        else $error("index does not match angle zero");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(st.irq_stat & st.irq_mask))
        else $error("interrupt output disagrees with masked status");

    strap_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st.pwr == QEO_STRAP) |=> (st.diag_mode == $past(output_release_n)))
        else $error("strap not caught");

    enable_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st.pwr == QEO_WAIT && comp_done && st.release_seen)
        |=> st.irq_stat[`QEO_IRQ_ENABLE_BIT])
        else $error("enable event lost");

    // bus timing
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready) |=> pready)
        else $error("no ready after one wait state");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && pready) |=> !pready)
        else $error("ready stood too long");

    bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready && !mapped)
        |=> (pready && pslverr && prdata == 32'h0000_0000))
        else $error("unmapped address not refused");

endmodule : qeo_encoder

`default_nettype wire

/* File: core/qeo_defs.svh */
// register offsets, field positions, reset values and timing counts of the encoder output stage
`ifndef QEO_DEFS_SVH
`define QEO_DEFS_SVH

// ********************************************************************
// register map (byte addresses on the apb bus)
// ********************************************************************
`define QEO_ADDR_W          12
`define QEO_CTRL_OFS        12'h000
`define QEO_STATUS_OFS      12'h004
`define QEO_IRQ_STAT_OFS    12'h008
`define QEO_IRQ_MASK_OFS    12'h00C

// ********************************************************************
// field positions
// ********************************************************************
`define QEO_CTRL_REV_BIT    0
`define QEO_ST_COMP_BIT     0
`define QEO_ST_DIAG_BIT     1
`define QEO_ST_REL_BIT      2
`define QEO_ST_RUN_BIT      3
`define QEO_ST_A_BIT        4
`define QEO_ST_B_BIT        5
`define QEO_ST_IDX_BIT      6
`define QEO_ST_POS_LSB      8
`define QEO_IRQ_INDEX_BIT   0
`define QEO_IRQ_INVALID_BIT 1
`define QEO_IRQ_MOVE_BIT    2
`define QEO_IRQ_ENABLE_BIT  3
`define QEO_IRQ_W           4

// ********************************************************************
// reset values
// ********************************************************************
`define QEO_CTRL_RST        1'b0
`define QEO_IRQ_MASK_RST    4'h0
`define QEO_IRQ_STAT_RST    4'h0

// ********************************************************************
// timing: offset compensation budget at a 200 mhz clock
// ********************************************************************
`define QEO_COMP_TIME_MS    50
`define QEO_CLK_MHZ         200
`define QEO_COMP_CYCLES     (`QEO_COMP_TIME_MS * 1000 * `QEO_CLK_MHZ)
`define QEO_COMP_CNT_W      24

`endif

/* File: core/qeo_pkg.sv */
// types shared by the encoder output stage modules
`include "qeo_defs.svh"

package qeo_pkg;

    // power-up sequencing of the incremental outputs
    typedef enum logic [1:0] {
        QEO_STRAP,
        QEO_WAIT,
        QEO_RUN
    } qeo_pwr_e;

    // state of the top level
    typedef struct packed {
        qeo_pwr_e                    pwr;
        logic                        diag_mode;
        logic                        release_seen;
        logic [`QEO_COMP_CNT_W-1:0]  comp_cnt;
        logic                        quad_a;
        logic                        quad_b;
        logic                        index_out;
        logic                        rev;
        logic [`QEO_IRQ_W-1:0]       irq_stat;
        logic [`QEO_IRQ_W-1:0]       irq_mask;
        logic                        irq;
        logic                        prev_invalid;
        logic                        prev_move;
        logic                        pready;
        logic                        pslverr;
        logic [31:0]                 prdata;
    } qeo_top_s;

    // state of the hysteresis tracker
    typedef struct packed {
        logic [7:0] pos;
    } qeo_hyst_s;

    // state of the field indicators
    typedef struct packed {
        logic up_on;
        logic down_on;
    } qeo_diag_s;

endpackage : qeo_pkg

/* File: core/qeo_hyst.sv */
// angle tracker with half-step hysteresis that moves the 8-bit position one step at a time, or straight to the angle while snap is high
`timescale 1ns/1ps
`default_nettype none

module qeo_hyst
    import qeo_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       snap,
    input  wire logic [8:0] fine_angle,
    output logic      [7:0] pos
);

    qeo_hyst_s   st;
    qeo_hyst_s   next_st;
    logic [8:0]  diff;

    // ********************************************************************
    // next position
    // ********************************************************************
    // fine angle has half an lsb per count, so one count is the hysteresis band
    always_comb begin
        next_st = st;
        diff    = fine_angle - {st.pos, 1'b0};
        if (snap) begin
            next_st.pos = fine_angle[8:1];
        end else if ($signed(diff) >= 9'sh002) begin
            next_st.pos = st.pos + 8'h01;
        end else if ($signed(diff) <= -9'sh002) begin
            next_st.pos = st.pos - 8'h01;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pos = st.pos;

    hyst_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !snap && ($signed(diff) < 9'sh002) && ($signed(diff) > -9'sh002)) |=> $stable(pos))
        else $error("position moved inside the hysteresis band");

    one_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !snap) |=> ((pos - $past(pos)) inside {8'h00, 8'h01, 8'hFF}))
        else $error("position moved more than one step");

endmodule : qeo_hyst

`default_nettype wire

/* File: core/qeo_field_diag.sv */
// field strength indicators driven as open-drain pins
`timescale 1ns/1ps
`default_nettype none

module qeo_field_diag
    import qeo_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic field_rising_flag,
    input  wire logic field_falling_flag,
    input  wire logic field_too_strong,
    input  wire logic field_too_weak,
    output logic      up_o,
    output logic      up_oe,
    output logic      down_o,
    output logic      down_oe
);

    qeo_diag_s st;
    qeo_diag_s next_st;
    logic      invalid;

    // ********************************************************************
    // indicator decode
    // ********************************************************************
    // rising and falling together with a valid field cancel out, as no clear motion
    always_comb begin
        next_st = '0;
        invalid = field_too_strong | field_too_weak;
        if (invalid) begin
            next_st.up_on   = 1'b1;
            next_st.down_on = 1'b1;
        end else begin
            next_st.up_on   = field_rising_flag & ~field_falling_flag;
            next_st.down_on = field_falling_flag & ~field_rising_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // on pulls low, off releases the line to the pull-up
    assign up_o    = 1'b0;
    assign down_o  = 1'b0;
    assign up_oe   = st.up_on;
    assign down_oe = st.down_on;

    inv_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && invalid) |=> (up_oe && down_oe))
        else $error("invalid field did not turn both indicators on");

    rise_up_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !invalid && field_rising_flag && !field_falling_flag) |=> (up_oe && !down_oe))
        else $error("rising field not shown on the up indicator");

    fall_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !invalid && field_falling_flag && !field_rising_flag) |=> (down_oe && !up_oe))
        else $error("falling field not shown on the down indicator");

    shared_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> ((up_oe || down_oe) == $past(invalid || field_rising_flag ^ field_falling_flag)))
        else $error("shared indicator line does not match field state");

    quiet_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !invalid && !field_rising_flag && !field_falling_flag) |=> !(up_oe || down_oe))
        else $error("indicator on with a steady in-range field");

endmodule : qeo_field_diag

`default_nettype wire

/* File: dv/qeo_host_model.sv */
// far-side controller model: pull-ups on the two indicator lines, alone and tied together
`timescale 1ns/1ps
`default_nettype none
module qeo_host_model (
    input  wire logic up_o,
    input  wire logic up_oe,
    input  wire logic dn_o,
    input  wire logic dn_oe,
    output logic      up_line,
    output logic      down_line,
    output logic      shared_line
);
    // a released line floats up to the pull-up, so only a driven low reads low
    assign up_line     = up_oe ? up_o : 1'b1;
    assign down_line   = dn_oe ? dn_o : 1'b1;
    assign shared_line = up_line & down_line;
endmodule : qeo_host_model
`default_nettype wire

/* File: dv/quadrature_encoder_output_diag_bench.sv */
// self-checking bench of the encoder output stage
`timescale 1ns/1ps
`default_nettype none
`include "qeo_defs.svh"
module quadrature_encoder_output_diag_bench;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        rf, ff, ts, tw, rel_n, qa, qb, idx, up_o, up_oe, dn_o, dn_oe;
    logic        up_line, down_line, shared_line;
    logic [3:0]  fin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  fine_angle;
    int          err_total, check_count;
    wire  [2:0]  abi = {qa, qb, idx};
    assign {rf, ff, ts, tw} = fin;
    qeo_encoder #(.COMP_CYCLES(20)) uut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .fine_angle(fine_angle), .field_rising_flag(rf),
        .field_falling_flag(ff), .field_too_strong(ts), .field_too_weak(tw),
        .output_release_n(rel_n), .quad_a(qa), .quad_b(qb), .index_out(idx),
        .field_up_indicator(up_o), .field_up_indicator_oe(up_oe), .field_down_indicator(dn_o),
        .field_down_indicator_oe(dn_oe), .irq(irq));
    qeo_host_model host (.up_o(up_o), .up_oe(up_oe), .dn_o(dn_o), .dn_oe(dn_oe),
        .up_line(up_line), .down_line(down_line), .shared_line(shared_line));
    // 200 mhz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; a hang here is cut by the watchdog
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic t_power(input logic strap);
        @(posedge pclk);
        presetn <= 1'b0;
        rel_n <= strap;
        fine_angle <= 9'h000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(abi, strap ? 3'b111 : 3'b000);
    endtask : t_power
    task automatic t_diag;
        repeat (30) @(posedge pclk);
        chk(abi, 3'b111);
        rel_n <= 1'b0;
        repeat (4) @(posedge pclk);
        rel_n <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(abi, 3'b001);
        apb(1'b0, `QEO_STATUS_OFS, 32'h0);
        chk(rd[3:0], 4'hF);
    endtask : t_diag
    // full clockwise turn, then a reversal inside and past the half-step band
    task automatic t_turn;
        logic [7:0] p;
        int         n;
        n = 0;
        repeat (14) @(posedge pclk);
        for (int i = 1; i <= 256; i++) begin
            p = i[7:0];
            fine_angle <= {p, 1'b0};
            repeat (4) @(posedge pclk);
            chk(abi, {p[1] ^ p[0], p[1], p == 8'h00});
            n += idx;
        end
        chk(n, 1);
        fine_angle <= 9'h1FF;
        repeat (4) @(posedge pclk);
        chk(abi, 3'b001);
        fine_angle <= 9'h1FE;
        repeat (4) @(posedge pclk);
        chk(abi, 3'b010);
    endtask : t_turn
    task automatic t_field;
        logic [5:0] tbl [5] = '{6'b100010, 6'b010001, 6'b001011, 6'b000111, 6'b000000};
        foreach (tbl[k]) begin
            fin <= tbl[k][5:2];
            repeat (3) @(posedge pclk);
            chk({up_oe, dn_oe}, tbl[k][1:0]);
            chk({up_line, down_line, shared_line}, {~tbl[k][1:0], tbl[k][1:0] == 2'b00});
        end
        ce  <= 1'b0;
        fin <= 4'b0010;
        repeat (3) @(posedge pclk);
        chk({up_oe, dn_oe}, 2'b00);
        ce  <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({up_oe, dn_oe}, 2'b11);
        fin <= 4'b0000;
        apb(1'b1, `QEO_IRQ_MASK_OFS, 32'h2);
        chk(irq, 1'b1);
        apb(1'b1, `QEO_IRQ_STAT_OFS, 32'hF);
        chk(irq, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
    endtask : t_field
    task automatic wrap_up;
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        {presetn, psel, penable, pwrite, fin, paddr, pwdata, fine_angle, rel_n} = '0;
        ce = 1'b1;
        err_total = 0;
        check_count = 0;
        t_power(1'b0);
        t_turn;
        t_field;
        t_power(1'b1);
        t_diag;
        wrap_up;
    end
    // watchdog well past the expected run of about 1200 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        wrap_up;
    end
endmodule : quadrature_encoder_output_diag_bench
`default_nettype wire
